// file: trd_core.sv
// table-read path, data memory decode and program store
// assumes the core issues a request only while busy_o is low
`timescale 1ns/1ps
module trd_core
    import trd_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire trd_req_t         req_i,
    input  wire logic             req_vld_i,
    output logic                  busy_o,
    output logic [DM_DW-1:0]      rdata_o,
    output logic                  rvalid_o,
    output logic                  done_o,
    output logic [DM_DW-1:0]      table_high_latch_o,
    input  wire logic             prog_en_i,
    input  wire logic             prog_serial_clock_i,
    input  wire logic             prog_serial_data_i,
    output logic                  prog_serial_data_o,
    output logic                  prog_serial_data_oe_o
);
    // ==========================================================
    // decode helpers
    function automatic logic is_gp(input logic [7:0] a);
        is_gp = a[7];
    endfunction

    function automatic logic sfr_writable(input logic [7:0] a);
        // latch and indirect slots refuse writes
        sfr_writable = (a == SFR_TPLO) || (a == SFR_TPHI);
    endfunction

    function automatic logic [7:0] bit_apply(input logic [7:0] v, input trd_req_t r);
        logic [7:0] t;
        t = v;
        t[r.bit_sel] = r.bit_val;
        bit_apply = t;
    endfunction

    // ==========================================================
    // program store 4K x 15, written by the serial programmer
    logic [PM_DW-1:0] pm_rd_q;
    logic [PM_AW-1:0] pm_addr;
    logic             pm_we;
    logic [PM_AW-1:0] pm_port_addr;
    logic [PRG_FRAME-1:0] frame;
    logic frame_vld;
    logic [PM_AW-1:0] prg_addr_q, prg_addr_d;

    // ==========================================================
    // state
    trd_state_t st_q, st_d;
    trd_req_t   rq_q, rq_d;
    logic [7:0] tplo_q, tplo_d, tphi_q, tphi_d, tbhi_q, tbhi_d;
    logic       busy_d, rvalid_d, done_d;
    logic [7:0] rdata_d;
    logic       ram_we;
    logic [6:0] ram_addr;
    logic [7:0] ram_wdata, ram_rdata;
    logic       rd_pend_q, rd_pend_d;
    logic [7:0] sfr_rd_q, sfr_rd_d;

    assign pm_addr = {tphi_q[3:0], tplo_q};

    // a frame lands only with bits 23:13 clear, so a garbled frame cannot corrupt code
    assign pm_we = frame_vld && (frame[PRG_FRAME-1:PM_AW+1] == 11'h000);

    // the write address wins; otherwise the programmer's pointer or the table pointer
    always_comb
    begin
        if (frame_vld)
        begin
            pm_port_addr = frame[PM_AW-1:0];
        end
        else if (prog_en_i)
        begin
            pm_port_addr = prg_addr_q;
        end
        else
        begin
            pm_port_addr = pm_addr;
        end
    end

    // one port serves programmer and table path, which never run together
    trd_ram #(
        .AW (PM_AW),
        .DW (PM_DW)
    ) u_prog_mem (
        .clk_i   (clk_i),
        .we_i    (pm_we),
        .addr_i  (pm_port_addr),
        .wdata_i (frame[PM_DW-1:0]),
        .rdata_o (pm_rd_q)
    );

    // ==========================================================
    // request sequencer
    always_comb
    begin
        st_d      = st_q;
        rq_d      = rq_q;
        tplo_d    = tplo_q;
        tphi_d    = tphi_q;
        tbhi_d    = tbhi_q;
        busy_d    = busy_o;
        rvalid_d  = 1'b0;
        done_d    = 1'b0;
        rdata_d   = rdata_o;
        ram_we    = 1'b0;
        ram_addr  = rq_q.addr[6:0];
        ram_wdata = rq_q.wdata;
        rd_pend_d = 1'b0;
        sfr_rd_d  = sfr_rd_q;
        prg_addr_d = frame_vld ? prg_addr_q + 12'h001 : prg_addr_q;
        if (rd_pend_q)
        begin
            rvalid_d = 1'b1;
            rdata_d  = is_gp(rq_q.addr) ? ram_rdata : sfr_rd_q;
        end
        case (st_q)
            TRD_IDLE:
            begin
                if (req_vld_i)
                begin
                    rq_d = req_i;
                    ram_addr = req_i.addr[6:0];
                    case (req_i.op)
                        TRD_OP_TABRD:
                        begin
                            st_d   = TRD_FETCH;
                            busy_d = 1'b1;
                        end
                        TRD_OP_RD:
                        begin
                            rd_pend_d = 1'b1;
                            // unused and indirect slots read as zero
                            case (req_i.addr)
                                SFR_TPLO: sfr_rd_d = tplo_q;
                                SFR_TPHI: sfr_rd_d = tphi_q;
                                SFR_TBHI: sfr_rd_d = tbhi_q;
                                default:  sfr_rd_d = 8'h00;
                            endcase
                        end
                        TRD_OP_WR:
                        begin
                            if (req_i.bit_en)
                            begin
                                st_d   = TRD_STORE; // read-modify-write
                                busy_d = 1'b1;
                            end
                            else if (is_gp(req_i.addr))
                            begin
                                ram_we    = 1'b1;
                                ram_wdata = req_i.wdata;
                                done_d    = 1'b1;
                            end
                            else
                            begin
                                done_d = 1'b1;
                                if (sfr_writable(req_i.addr))
                                begin
                                    if (req_i.addr == SFR_TPLO)
                                    begin
                                        tplo_d = req_i.wdata;
                                    end
                                    else
                                    begin
                                        tphi_d = req_i.wdata;
                                    end
                                end
                            end
                        end
                        default:
                        begin
                            st_d = TRD_IDLE;
                        end
                    endcase
                end
            end
            TRD_FETCH:
            begin
                // second instruction cycle: pm_rd_q now holds the word
                tbhi_d = {1'b0, pm_rd_q[PM_DW-1:8]};
                st_d   = TRD_IDLE;
                busy_d = 1'b0;
                done_d = 1'b1;
                if (is_gp(rq_q.addr))
                begin
                    ram_we    = 1'b1;
                    ram_wdata = pm_rd_q[7:0];
                end
                else if (sfr_writable(rq_q.addr))
                begin
                    if (rq_q.addr == SFR_TPLO)
                    begin
                        tplo_d = pm_rd_q[7:0];
                    end
                    else
                    begin
                        tphi_d = pm_rd_q[7:0];
                    end
                end
                // pointers otherwise untouched
            end
            TRD_STORE:
            begin
                st_d   = TRD_IDLE;
                busy_d = 1'b0;
                done_d = 1'b1;
                if (is_gp(rq_q.addr))
                begin
                    ram_we    = 1'b1;
                    ram_wdata = bit_apply(ram_rdata, rq_q);
                end
                else if (rq_q.addr == SFR_TPLO)
                begin
                    tplo_d = bit_apply(tplo_q, rq_q);
                end
                else if (rq_q.addr == SFR_TPHI)
                begin
                    tphi_d = bit_apply(tphi_q, rq_q);
                end
            end
            default:
            begin
                st_d   = TRD_IDLE;
                busy_d = 1'b0;
            end
        endcase
        if (!prog_en_i)
        begin
            prg_addr_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_q       <= TRD_IDLE;
            rq_q       <= '0;
            tplo_q     <= TPLO_RST;
            tphi_q     <= TPHI_RST;
            tbhi_q     <= TBHI_RST;
            busy_o     <= 1'b0;
            rvalid_o   <= 1'b0;
            done_o     <= 1'b0;
            rdata_o    <= 8'h00;
            rd_pend_q  <= 1'b0;
            sfr_rd_q   <= 8'h00;
            prg_addr_q <= '0;
        end
        else
        begin
            st_q       <= st_d;
            rq_q       <= rq_d;
            tplo_q     <= tplo_d;
            tphi_q     <= tphi_d;
            tbhi_q     <= tbhi_d;
            busy_o     <= busy_d;
            rvalid_o   <= rvalid_d;
            done_o     <= done_d;
            rdata_o    <= rdata_d;
            rd_pend_q  <= rd_pend_d;
            sfr_rd_q   <= sfr_rd_d;
            prg_addr_q <= prg_addr_d;
        end
    end

    // no write path reaches the latch, so an interrupted reader cannot restore it
    assign table_high_latch_o = tbhi_q;

    // ==========================================================
    // general purpose RAM, 128 bytes at 80H..FFH
    trd_ram #(
        .AW (7),
        .DW (DM_DW)
    ) u_gp_ram (
        .clk_i   (clk_i),
        .we_i    (ram_we),
        .addr_i  (ram_addr),
        .wdata_i (ram_wdata),
        .rdata_o (ram_rdata)
    );

    // ==========================================================
    // serial programming port
    trd_prog_shift u_prog (
        .clk_i                 (clk_i),
        .nrst_i                (nrst_i),
        .prog_en_i             (prog_en_i),
        .prog_serial_clock_i   (prog_serial_clock_i),
        .prog_serial_data_i    (prog_serial_data_i),
        .dir_out_i             (1'b0),
        .load_data_i           (pm_rd_q),
        .prog_serial_data_o    (prog_serial_data_o),
        .prog_serial_data_oe_o (prog_serial_data_oe_o),
        .frame_o               (frame),
        .frame_vld_o           (frame_vld)
    );
endmodule

// file: trd_core_chk.sv
// checker for the table-read and data-memory block
// assumes a single clk_i domain, bound to trd_core from the bench
`timescale 1ns/1ps
module trd_core_chk
    import trd_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             nrst_i,
    input wire trd_req_t         req_i,
    input wire logic             req_vld_i,
    input wire logic             busy_o,
    input wire logic [DM_DW-1:0] rdata_o,
    input wire logic             rvalid_o,
    input wire logic             done_o,
    input wire logic [DM_DW-1:0] table_high_latch_o,
    input wire logic             prog_en_i,
    input wire logic             prog_serial_clock_i,
    input wire logic             prog_serial_data_i,
    input wire logic             prog_serial_data_o,
    input wire logic             prog_serial_data_oe_o
);
    // ==========================================================
    // helpers
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic take;
    logic take_tab;
    logic sfr_void;
    // a request counts only when the block is free
    assign take     = req_vld_i && !busy_o;
    assign take_tab = take && req_i.op == TRD_OP_TABRD;
    assign sfr_void = req_i.addr <= SFR_LIMIT && req_i.addr != SFR_TPLO
                      && req_i.addr != SFR_TBHI && req_i.addr != SFR_TPHI;

    // ==========================================================
    // assertions
    property p_tab_two;
        take_tab |=> busy_o && !done_o ##1 !busy_o && done_o;
    endproperty
    a_tab_two: assert property (p_tab_two)
        else $error("table read did not take two cycles");
    property p_bit_two;
        take && req_i.op == TRD_OP_WR && req_i.bit_en |=> busy_o ##1 done_o;
    endproperty
    a_bit_two: assert property (p_bit_two)
        else $error("bit op did not end in two cycles");
    property p_wr_done;
        take && req_i.op == TRD_OP_WR && !req_i.bit_en |=> done_o && !busy_o;
    endproperty
    a_wr_done: assert property (p_wr_done)
        else $error("write not done next cycle");
    property p_rd_lat;
        take && req_i.op == TRD_OP_RD |-> ##2 rvalid_o;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read data late");
    property p_sfr_zero;
        take && req_i.op == TRD_OP_RD && sfr_void |-> ##2 rdata_o == 8'h00;
    endproperty
    a_sfr_zero: assert property (p_sfr_zero)
        else $error("special read not zero");
    property p_latch_msb;
        table_high_latch_o[7] == 1'b0;
    endproperty
    a_latch_msb: assert property (p_latch_msb)
        else $error("latch top bit set");
    // only a taken table read may move the latch
    property p_latch_cause;
        $changed(table_high_latch_o) |-> $past(take_tab, 2);
    endproperty
    a_latch_cause: assert property (p_latch_cause)
        else $error("latch changed without table read");
    property p_rdata_cause;
        $changed(rdata_o) |-> rvalid_o;
    endproperty
    a_rdata_cause: assert property (p_rdata_cause)
        else $error("read data moved without valid");
    property p_oe_off;
        !prog_serial_data_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("serial pin driven");

    // ==========================================================
    // coverage
    c_tab: cover property (take_tab);
    c_bit: cover property (take && req_i.bit_en);
    c_refused: cover property (req_vld_i && busy_o);
endmodule

// file: trd_core_tb.sv
// self-checking bench for trd_core
// assumes the serial model fills program memory before table reads
`timescale 1ns/1ps
module trd_core_tb
    import trd_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } trd_row_t;

    logic       clk_i, nrst_i, req_vld_i, busy_o, rvalid_o, done_o;
    logic       prog_en_i, prog_serial_clock_i, prog_serial_data_i;
    logic       prog_serial_data_o, prog_serial_data_oe_o;
    logic [7:0] rdata_o, table_high_latch_o;
    trd_req_t   req_i;
    int         num_errors = 0;
    int         compares = 0;

    // write then read back; special places mostly refuse
    localparam trd_row_t ROWS [9] = '{
        '{8'h80, 8'hA5, 8'hA5}, '{8'hFF, 8'h5A, 8'h5A}, '{8'hC3, 8'h3C, 8'h3C},
        '{8'h07, 8'h12, 8'h12}, '{8'h09, 8'h0F, 8'h0F}, '{8'h08, 8'hFF, 8'h00},
        '{8'h00, 8'h77, 8'h00}, '{8'h7F, 8'h77, 8'h00}, '{8'h40, 8'h33, 8'h00}};

    // ==========================================================
    // instances
    trd_core dut (
        .clk_i                 (clk_i),
        .nrst_i                (nrst_i),
        .req_i                 (req_i),
        .req_vld_i             (req_vld_i),
        .busy_o                (busy_o),
        .rdata_o               (rdata_o),
        .rvalid_o              (rvalid_o),
        .done_o                (done_o),
        .table_high_latch_o    (table_high_latch_o),
        .prog_en_i             (prog_en_i),
        .prog_serial_clock_i   (prog_serial_clock_i),
        .prog_serial_data_i    (prog_serial_data_i),
        .prog_serial_data_o    (prog_serial_data_o),
        .prog_serial_data_oe_o (prog_serial_data_oe_o)
    );
    trd_prog_model u_prog (
        .clk_i               (clk_i),
        .prog_en_o           (prog_en_i),
        .prog_serial_clock_o (prog_serial_clock_i),
        .prog_serial_data_o  (prog_serial_data_i)
    );

    // ==========================================================
    // clock and watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (8000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    // ==========================================================
    // tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic trd_req_t mk(trd_op_t op, logic [7:0] a, logic [7:0] d,
                                    logic be = 1'b0, logic [2:0] s = 3'h0, logic v = 1'b0);
        return '{op, a, d, be, s, v};
    endfunction
    // frame: bits 11:0 address, bit 12 spare data bit, rest zero
    function automatic logic [23:0] frm(logic b, logic [11:0] a);
        return {11'h000, b, a};
    endfunction
    // inj drives a write in the busy cycle, which must be ignored; returns while the answer stands
    task automatic issue(input trd_req_t r, input logic inj);
        @(posedge clk_i);
        req_i     <= r;
        req_vld_i <= 1'b1;
        @(posedge clk_i);
        req_vld_i <= inj;
        if (inj)
        begin
            req_i <= mk(TRD_OP_WR, r.addr, 8'hEE);
        end
        if (r.op != TRD_OP_WR || r.bit_en)
        begin
            @(posedge clk_i);
            req_vld_i <= 1'b0;
        end
        @(negedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        issue(mk(TRD_OP_WR, a, d), 1'b0);
        chk1(done_o, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        issue(mk(TRD_OP_RD, a, 8'h00), 1'b0);
        chk1(rvalid_o, 1'b1);
        chk8(rdata_o, exp);
    endtask
    task automatic tab(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] dst,
                       input logic [7:0] elo, input logic [7:0] ehi, input logic inj);
        wr(SFR_TPHI, hi);
        wr(SFR_TPLO, lo);
        issue(mk(TRD_OP_TABRD, dst, 8'h00), inj);
        chk1(done_o, 1'b1);
        chk8(table_high_latch_o, ehi);
        rd(dst, elo);
        rd(SFR_TPLO, lo);
        rd(SFR_TPHI, hi);
    endtask
    task report_and_stop;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        nrst_i    = 1'b0;
        req_vld_i = 1'b0;
        req_i     = mk(TRD_OP_NONE, 8'h00, 8'h00);
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk1(busy_o, 1'b0);
        chk8(table_high_latch_o, TBHI_RST);
        u_prog.send(frm(1'b1, 12'hF06));
        u_prog.send(frm(1'b1, 12'h000));
        u_prog.send(frm(1'b0, 12'hFFF));
        foreach (ROWS[i])
        begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd(ROWS[i].addr, ROWS[i].exp);
        end
        tab(8'h0F, 8'h06, 8'h90, 8'h06, 8'h1F, 1'b1);
        rd(SFR_TBHI, 8'h1F);
        wr(SFR_TBHI, 8'h00);
        rd(SFR_TBHI, 8'h1F);
        tab(8'h00, 8'h00, 8'hFF, 8'h00, 8'h10, 1'b0);
        tab(8'h0F, 8'hFF, 8'h81, 8'hFF, 8'h0F, 1'b0);
        issue(mk(TRD_OP_WR, 8'h80, 8'h00, 1'b1, 3'h3, 1'b1), 1'b0);
        chk1(done_o, 1'b1);
        rd(8'h80, 8'hAD);
        issue(mk(TRD_OP_WR, 8'h80, 8'h00, 1'b1, 3'h0, 1'b0), 1'b0);
        rd(8'h80, 8'hAC);
        report_and_stop();
    end
endmodule

bind trd_core trd_core_chk u_chk (
    .clk_i                 (clk_i),
    .nrst_i                (nrst_i),
    .req_i                 (req_i),
    .req_vld_i             (req_vld_i),
    .busy_o                (busy_o),
    .rdata_o               (rdata_o),
    .rvalid_o              (rvalid_o),
    .done_o                (done_o),
    .table_high_latch_o    (table_high_latch_o),
    .prog_en_i             (prog_en_i),
    .prog_serial_clock_i   (prog_serial_clock_i),
    .prog_serial_data_i    (prog_serial_data_i),
    .prog_serial_data_o    (prog_serial_data_o),
    .prog_serial_data_oe_o (prog_serial_data_oe_o)
);

// file: trd_pkg.sv
// package of constants and carrier types for the table-read and data-memory block
// assumes a core that issues one request at a time on clk_i, synchronous to it
// Summary of operation
// - each table read loads the fetched word's high part into the table-high latch
// - table address is pointer-high concatenated with pointer-low, spanning 4K words
// - table-high latch is read-only; writes to it are ignored
// - every table-related instruction takes two instruction cycles
// - data memory is volatile RAM with 8-bit words
// - addresses 00H to 7FH decode to the special function area
// - addresses 80H to FFH decode to general purpose RAM
// - all general purpose RAM reads and writes freely, unprotected
// - bit operations set or clear one bit, other bits unchanged
// - special locations are fixed; some refuse writes, others read and write
// - programming shifts data serially on one pin clocked by the programmer
// - table read writes the fetched low byte into the named data register
// - latch bits without a program-word bit read as zero
// - program memory holds 4K words of 15 bits
package trd_pkg;

    // ==========================================================
    // sizes
    localparam int PM_AW    = 12;
    localparam int PM_DW    = 15;
    localparam int PM_DEPTH = 4096;
    localparam int DM_AW    = 8;
    localparam int DM_DW    = 8;
    localparam int GP_DEPTH = 128;

    // ==========================================================
    // special function offsets
    localparam logic [7:0] SFR_IND0  = 8'h00;
    localparam logic [7:0] SFR_IND1  = 8'h02;
    localparam logic [7:0] SFR_TPLO  = 8'h07;
    localparam logic [7:0] SFR_TBHI  = 8'h08;
    localparam logic [7:0] SFR_TPHI  = 8'h09;
    localparam logic [7:0] SFR_LIMIT = 8'h7F;
    localparam logic [7:0] GP_BASE   = 8'h80;

    // ==========================================================
    // reset values
    localparam logic [7:0] TPLO_RST = 8'h00;
    localparam logic [7:0] TPHI_RST = 8'h00;
    localparam logic [7:0] TBHI_RST = 8'h00;

    // ==========================================================
    // serial programming port
    localparam int          PRG_FRAME = 24;
    localparam logic [4:0]  PRG_CNT_W = 5'h17;

    typedef enum logic [1:0] {
        TRD_OP_NONE  = 2'h0,
        TRD_OP_RD    = 2'h1,
        TRD_OP_WR    = 2'h2,
        TRD_OP_TABRD = 2'h3
    } trd_op_t;

    typedef struct packed {
        trd_op_t    op;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       bit_en;
        logic [2:0] bit_sel;
        logic       bit_val;
    } trd_req_t;

    typedef enum logic [1:0] {
        TRD_IDLE  = 2'b00,
        TRD_FETCH = 2'b01,
        TRD_STORE = 2'b10
    } trd_state_t;

endpackage

// file: trd_prog_model.sv
// model of the serial programmer that fills program memory
// assumes the block samples the programmer clock on clk_i
`timescale 1ns/1ps
module trd_prog_model
    import trd_pkg::*;
(
    input  wire logic clk_i,
    output logic      prog_en_o,
    output logic      prog_serial_clock_o,
    output logic      prog_serial_data_o
);
    // ==========================================================
    // idle levels: clock stands still low outside frames
    initial
    begin
        prog_en_o           = 1'b0;
        prog_serial_clock_o = 1'b0;
        prog_serial_data_o  = 1'b0;
    end

    // one frame, lsb first, data set two cycles before the rising edge
    task automatic send(input logic [PRG_FRAME-1:0] f);
        @(posedge clk_i);
        prog_en_o <= 1'b1;
        for (int i = 0; i < PRG_FRAME; i++)
        begin
            repeat (2) @(posedge clk_i);
            prog_serial_data_o <= f[i];
            repeat (2) @(posedge clk_i);
            prog_serial_clock_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            prog_serial_clock_o <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        prog_serial_data_o <= ~f[PRG_FRAME-1]; // driven to the complement of the last bit, so no stale bit
        repeat (4) @(posedge clk_i);
        prog_en_o <= 1'b0;
    endtask
endmodule

// file: trd_prog_shift.sv
// serial programming shifter: one data pin, clock from the programmer
// assumes prog clock is sampled as an ordinary synchronous input
`timescale 1ns/1ps
module trd_prog_shift
    import trd_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 prog_en_i,
    input  wire logic                 prog_serial_clock_i,
    input  wire logic                 prog_serial_data_i,
    input  wire logic                 dir_out_i,
    input  wire logic [PM_DW-1:0]     load_data_i,
    output logic                      prog_serial_data_o,
    output logic                      prog_serial_data_oe_o,
    output logic [PRG_FRAME-1:0]      frame_o,
    output logic                      frame_vld_o
);
    // ==========================================================
    // shift register
    logic                 ck_q, ck_d;
    logic [PRG_FRAME-1:0] sh_q, sh_d;
    logic [4:0]           cnt_q, cnt_d;
    logic                 vld_d, dout_d, oe_d;

    // rising programmer clock shifts in, falling edge changes output
    always_comb
    begin
        ck_d   = prog_serial_clock_i;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        vld_d  = 1'b0;
        dout_d = prog_serial_data_o;
        oe_d   = prog_en_i & dir_out_i;
        if (!prog_en_i)
        begin
            cnt_d = '0;
            sh_d  = {{(PRG_FRAME-PM_DW){1'b0}}, load_data_i};
        end
        else if (prog_serial_clock_i && !ck_q)
        begin
            sh_d = {prog_serial_data_i, sh_q[PRG_FRAME-1:1]};
            if (cnt_q == PRG_CNT_W)
            begin
                cnt_d = '0;
                vld_d = ~dir_out_i;
            end
            else
            begin
                cnt_d = cnt_q + 5'h01;
            end
        end
        else if (!prog_serial_clock_i && ck_q)
        begin
            dout_d = sh_q[0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ck_q                  <= 1'b0;
            sh_q                  <= '0;
            cnt_q                 <= '0;
            frame_vld_o           <= 1'b0;
            prog_serial_data_o    <= 1'b0;
            prog_serial_data_oe_o <= 1'b0;
        end
        else
        begin
            ck_q                  <= ck_d;
            sh_q                  <= sh_d;
            cnt_q                 <= cnt_d;
            frame_vld_o           <= vld_d;
            prog_serial_data_o    <= dout_d;
            prog_serial_data_oe_o <= oe_d;
        end
    end

    assign frame_o = sh_q;
endmodule

// file: trd_ram.sv
// single-port memory of DW-bit words with registered read data
// assumes one access per clock, write and read never in the same cycle
`timescale 1ns/1ps
module trd_ram
    import trd_pkg::*;
#(
    parameter int AW = 7,
    parameter int DW = 8
)(
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    // ==========================================================
    // storage
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // contents are volatile, so no reset on the array
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule
